// [design/ssmc_pkg.sv]
// Shared constants and types for the sleep-mode control of the flow-through SRAM.
// Assumes one SRAM clock; all counts are in clock cycles of that clock.
package ssmc_pkg;

    // Array geometry defaults
    localparam int ADDR_W_DEF = 18;
    localparam int DATA_W_DEF = 36;

    // Sleep entry and exit windows, in cycles
    localparam int         CNT_W            = 2;
    localparam logic [1:0] ENTER_CYCLES     = 2'h2;
    localparam logic [1:0] WAKE_CYCLES      = 2'h2;
    localparam logic [1:0] CNT_RESET        = 2'h0;
    localparam logic [1:0] CNT_FIRST        = 2'h1;

    typedef enum logic [1:0] {
        SSMC_AWAKE,
        SSMC_ENTER,
        SSMC_ASLEEP,
        SSMC_WAKE
    } ssmc_state_t;

endpackage

// [design/ssmc_seq_if.sv]
// Carrier between the SRAM core logic and its sleep sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssmc_seq_if;
    logic sleep_req;
    logic inputs_ignored;
    logic asleep;

    modport seq (
        input  sleep_req,
        output inputs_ignored,
        output asleep
    );

    modport core (
        output sleep_req,
        input  inputs_ignored,
        input  asleep
    );
endinterface
`default_nettype wire

// [design/ssmc_sleep_seq.sv]
// Sleep sequencer: decides in which cycles the synchronous inputs are sampled.
// Assumes sleep_req is already aligned to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ssmc_sleep_seq (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // Sleep status towards the core
    ssmc_seq_if.seq     sif
);
    import ssmc_pkg::*;

    typedef struct packed {
        ssmc_state_t       st;
        logic [CNT_W-1:0]  cnt;
    } ssmc_seq_state_t;

    ssmc_seq_state_t s_reg;
    ssmc_seq_state_t s_next;

    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            SSMC_AWAKE: begin
                if (sif.sleep_req) begin
                    s_next.st  = SSMC_ENTER;
                    s_next.cnt = CNT_FIRST;
                end
            end
            SSMC_ENTER: begin
                // Inputs still sampled here
                if (!sif.sleep_req) begin
                    s_next.st = SSMC_AWAKE;
                end else if (s_reg.cnt == ENTER_CYCLES - CNT_FIRST) begin
                    s_next.st = SSMC_ASLEEP;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_FIRST;
                end
            end
            SSMC_ASLEEP: begin
                // Stays asleep as long as the request is high
                if (!sif.sleep_req) begin
                    s_next.st  = SSMC_WAKE;
                    s_next.cnt = CNT_FIRST;
                end
            end
            SSMC_WAKE: begin
                // Inputs stay ignored until the wake window has run out
                if (sif.sleep_req) begin
                    s_next.st = SSMC_ASLEEP;
                end else if (s_reg.cnt == WAKE_CYCLES - CNT_FIRST) begin
                    s_next.st = SSMC_AWAKE;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_FIRST;
                end
            end
            default: begin
                s_next.st  = SSMC_AWAKE;
                s_next.cnt = CNT_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg.st  <= SSMC_AWAKE;
            s_reg.cnt <= CNT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sif.inputs_ignored = (s_reg.st == SSMC_ASLEEP) || (s_reg.st == SSMC_WAKE);
    assign sif.asleep         = (s_reg.st == SSMC_ASLEEP);

    sequence s_req_two;
        sif.sleep_req ##1 sif.sleep_req;
    endsequence

    property p_enter_after_two;
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.st == SSMC_AWAKE) ##0 s_req_two |=> sif.inputs_ignored;
    endproperty
    a_enter_after_two: assert property (p_enter_after_two) else $error("sleep not entered after two cycles");

    property p_enter_min;
        @(posedge clk_i) disable iff (rst_i)
        $rose(sif.inputs_ignored) && $past(s_reg.st) != SSMC_WAKE |-> $past(sif.sleep_req, 1) && $past(sif.sleep_req, 2);
    endproperty
    a_enter_min: assert property (p_enter_min) else $error("inputs ignored too early after sleep request");

    property p_wake_min;
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.st == SSMC_ASLEEP && !sif.sleep_req) |-> sif.inputs_ignored ##1 sif.inputs_ignored;
    endproperty
    a_wake_min: assert property (p_wake_min) else $error("inputs sampled too early after wake");

    property p_wake_done;
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.st == SSMC_ASLEEP && !sif.sleep_req) ##1 !sif.sleep_req |=> !sif.inputs_ignored;
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("inputs not sampled again after wake window");

    property p_stay_asleep;
        @(posedge clk_i) disable iff (rst_i)
        sif.asleep && sif.sleep_req |=> sif.asleep;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep while request high");

endmodule
`default_nettype wire

// [design/ssmc_sram_sleep_mode_control.sv]
// Top of the SRAM sleep-mode control: cycle start qualification, array, data output.
// Assumes all inputs are synchronous to CLK_I; the controller keeps its own timing duties.
// Functional notes
// - Sleep request is active high and puts the part into low-current sleep.
// - Asleep means deselected; sleep lasts as long as the request stays high.
// - Once asleep, all inputs but sleep request are ignored; data outputs float.
// - Inputs keep being sampled at least two cycles after the request rises.
// - Inputs are not sampled again until two cycles after the request falls.
// - A strobe cycle enables the part only if both extra chip selects are active.
// - Two extra chip selects let two parts share a bus without decode logic.
// - Sleep request and output enable override the synchronously decoded output enable.
`timescale 1ns/1ps
`default_nettype none
module ssmc_sram_sleep_mode_control #(
    parameter int ADDR_W = ssmc_pkg::ADDR_W_DEF,
    parameter int DATA_W = ssmc_pkg::DATA_W_DEF
) (
    // Clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    // Sleep control
    input  wire logic              SLEEP_REQUEST_I,
    output logic                   SLEEP_O,
    // Cycle start and selects
    input  wire logic              PROCESSOR_ADDRESS_STROBE_N_I,
    input  wire logic              CONTROLLER_ADDRESS_STROBE_N_I,
    input  wire logic              CHIP_SELECT_N_I,
    input  wire logic              EXP_SELECT_I,
    input  wire logic              EXP_SELECT_N_I,
    // Access
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic              WRITE_N_I,
    input  wire logic              OUTPUT_ENABLE_N_I,
    input  wire logic [DATA_W-1:0] DQ_I,
    output logic      [DATA_W-1:0] DQ_O,
    output logic                   DQ_OE_N_O
);
    import ssmc_pkg::*;

    typedef struct packed {
        logic              selected;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              dq_oe_n;
        logic              sleep;
    } ssmc_core_state_t;

    ssmc_core_state_t c_reg;
    ssmc_core_state_t c_next;

    // Array has no reset so that contents survive both sleep and reset
    logic [DATA_W-1:0] mem [2**ADDR_W];

    ssmc_seq_if sif ();

    logic              ign;
    logic              cs_ok;
    logic              start_c;
    logic              start_p;
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] acc_addr;

    assign sif.sleep_req = SLEEP_REQUEST_I;

    ssmc_sleep_seq u_seq (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .sif   (sif)
    );

    assign ign   = sif.inputs_ignored;
    assign cs_ok = !CHIP_SELECT_N_I && EXP_SELECT_I && !EXP_SELECT_N_I;
    // Controller strobe is gated while waking as well as asleep, so ign covers it
    assign start_c = !ign && !CONTROLLER_ADDRESS_STROBE_N_I;
    // Primary select high blocks the processor strobe
    assign start_p = !ign && !PROCESSOR_ADDRESS_STROBE_N_I && !CHIP_SELECT_N_I;

    always_comb begin
        c_next   = c_reg;
        wr_en    = 1'b0;
        rd_en    = 1'b0;
        acc_addr = c_reg.addr;
        if (ign) begin
            // Deselected and deaf while asleep or waking
            c_next.selected = 1'b0;
        end else if (start_c || start_p) begin
            c_next.selected = cs_ok;
            c_next.addr     = ADDR_I;
            acc_addr        = ADDR_I;
            // Processor strobe always opens with a read
            wr_en           = cs_ok && start_c && !start_p && !WRITE_N_I;
            rd_en           = cs_ok && !wr_en;
        end else if (c_reg.selected) begin
            wr_en = !WRITE_N_I;
            rd_en = WRITE_N_I;
        end
        if (rd_en) begin
            c_next.dq = mem[acc_addr];
        end
        // Output enable and sleep request levels, sampled on the same edge, have the last word over the decoded cycle
        c_next.dq_oe_n = !(rd_en && !OUTPUT_ENABLE_N_I && !SLEEP_REQUEST_I);
        c_next.sleep   = sif.asleep;
    end

    // Writes are complete per cycle, so nothing is in flight at sleep entry
    always_ff @(posedge CLK_I) begin
        if (wr_en) begin
            mem[acc_addr] <= DQ_I;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            c_reg.selected <= 1'b0;
            c_reg.addr     <= '0;
            c_reg.dq       <= '0;
            c_reg.dq_oe_n  <= 1'b1;
            c_reg.sleep    <= 1'b0;
        end else begin
            c_reg <= c_next;
        end
    end

    assign SLEEP_O   = c_reg.sleep;
    assign DQ_O      = c_reg.dq;
    assign DQ_OE_N_O = c_reg.dq_oe_n;

    property p_desel_ign;
        @(posedge CLK_I) disable iff (RST_I)
        ign |=> !c_reg.selected;
    endproperty
    a_desel_ign: assert property (p_desel_ign) else $error("selected while asleep");

    property p_float_ign;
        @(posedge CLK_I) disable iff (RST_I)
        ign |=> DQ_OE_N_O;
    endproperty
    a_float_ign: assert property (p_float_ign) else $error("data driven while asleep");

    property p_no_write_ign;
        @(posedge CLK_I) disable iff (RST_I)
        ign |-> !wr_en && !rd_en;
    endproperty
    a_no_write_ign: assert property (p_no_write_ign) else $error("access while inputs ignored");

    property p_cs_reject;
        @(posedge CLK_I) disable iff (RST_I)
        (start_c || start_p) && !cs_ok |=> !c_reg.selected && DQ_OE_N_O;
    endproperty
    a_cs_reject: assert property (p_cs_reject) else $error("enabled without both chip selects");

    property p_cs_accept;
        @(posedge CLK_I) disable iff (RST_I)
        (start_c || start_p) && cs_ok |=> c_reg.selected;
    endproperty
    a_cs_accept: assert property (p_cs_accept) else $error("not enabled with all selects active");

    property p_sleep_override;
        @(posedge CLK_I) disable iff (RST_I)
        SLEEP_REQUEST_I || OUTPUT_ENABLE_N_I |=> DQ_OE_N_O;
    endproperty
    a_sleep_override: assert property (p_sleep_override) else $error("output not overridden");

    property p_sleep_flag;
        @(posedge CLK_I) disable iff (RST_I)
        sif.asleep |=> SLEEP_O ##1 (SLEEP_O || !$past(SLEEP_REQUEST_I, 2));
    endproperty
    a_sleep_flag: assert property (p_sleep_flag) else $error("sleep status not shown");

    property p_read_data;
        @(posedge CLK_I) disable iff (RST_I)
        rd_en && !OUTPUT_ENABLE_N_I && !SLEEP_REQUEST_I |=> !DQ_OE_N_O && DQ_O == $past(mem[acc_addr]);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong or not driven");

    sequence s_req_rise;
        !SLEEP_REQUEST_I ##1 SLEEP_REQUEST_I;
    endsequence

    // First edge with the request high is still sampled, so is the next one
    property p_sample_window;
        @(posedge CLK_I) disable iff (RST_I)
        s_req_rise ##0 !ign |=> !ign;
    endproperty
    a_sample_window: assert property (p_sample_window) else $error("inputs ignored too soon after request");

    property p_proc_blocked;
        @(posedge CLK_I) disable iff (RST_I)
        !ign && !PROCESSOR_ADDRESS_STROBE_N_I && CHIP_SELECT_N_I && CONTROLLER_ADDRESS_STROBE_N_I
            |=> $stable(c_reg.selected) && $stable(c_reg.addr);
    endproperty
    a_proc_blocked: assert property (p_proc_blocked) else $error("processor strobe not blocked by select");

    property p_sleep_float;
        @(posedge CLK_I) disable iff (RST_I)
        SLEEP_O |-> DQ_OE_N_O;
    endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("data driven while sleep shown");

    property p_sleep_desel;
        @(posedge CLK_I) disable iff (RST_I)
        SLEEP_O |-> !c_reg.selected;
    endproperty
    a_sleep_desel: assert property (p_sleep_desel) else $error("selected while sleep shown");

    // Read data is held between reads so a late sampler still sees it
    property p_dq_hold;
        @(posedge CLK_I) disable iff (RST_I)
        !rd_en |=> $stable(DQ_O);
    endproperty
    a_dq_hold: assert property (p_dq_hold) else $error("read data changed without a read");

    property p_write_needs_cs;
        @(posedge CLK_I) disable iff (RST_I)
        wr_en && !c_reg.selected |-> start_c && cs_ok && !WRITE_N_I;
    endproperty
    a_write_needs_cs: assert property (p_write_needs_cs) else $error("write without a selected strobe");

    property p_reject_no_access;
        @(posedge CLK_I) disable iff (RST_I)
        (start_c || start_p) && !cs_ok |-> !wr_en && !rd_en;
    endproperty
    a_reject_no_access: assert property (p_reject_no_access) else $error("access with a select inactive");

endmodule
`default_nettype wire

// [tb/ssmc_ctrl_model.sv]
// Controller model: drives the SRAM bus side of the sleep-mode control.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module ssmc_ctrl_model (
    // Clock
    input  wire logic   clk_i,
    // SRAM bus
    output logic        sleep_o,
    output logic        pstb_n_o,
    output logic        cstb_n_o,
    output logic [2:0]  sel_o,
    output logic        write_n_o,
    output logic        oe_n_o,
    output logic [17:0] addr_o,
    output logic [35:0] data_o
);
    task automatic idle();
        pstb_n_o = 1'b1;
        cstb_n_o = 1'b1;
        sel_o = 3'h7;
        write_n_o = 1'b1;
        // Released bus must not look like held data
        data_o = ~data_o;
    endtask

    task automatic op(input logic p, c, w, oe, input logic [2:0] s,
                      input logic [17:0] a, input logic [35:0] d);
        @(posedge clk_i);
        #1;
        pstb_n_o = p;
        cstb_n_o = c;
        sel_o = s;
        write_n_o = w;
        oe_n_o = oe;
        addr_o = a;
        data_o = d;
        @(posedge clk_i);
        #1;
        idle();
    endtask

    // Callers raise sleep only once op has returned
    task automatic slp(input logic v);
        @(posedge clk_i);
        #1;
        sleep_o = v;
        if (!v)
            repeat (2) @(posedge clk_i);
        #1;
    endtask

    initial begin
        sleep_o = 1'b0;
        oe_n_o = 1'b0;
        addr_o = 18'h0;
        data_o = 36'h0;
        idle();
    end
endmodule
`default_nettype wire

// [tb/ssmc_tb.sv]
// Bench for the SRAM sleep-mode control.
// Assumes the controller model drives every bus input.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [2:0] GOOD = 3'h2;
    logic        clk;
    logic        rst;
    logic        slp_req;
    logic        pn;
    logic        cn;
    logic        wn;
    logic        oen;
    logic [2:0]  sel;
    logic [17:0] addr;
    logic [35:0] din;
    logic [35:0] dout;
    logic        slp_st;
    logic        dq_oe_n;
    int          num_errors = 0;
    int          checks = 0;

    ssmc_ctrl_model m (
        .clk_i     (clk),
        .sleep_o   (slp_req),
        .pstb_n_o  (pn),
        .cstb_n_o  (cn),
        .sel_o     (sel),
        .write_n_o (wn),
        .oe_n_o    (oen),
        .addr_o    (addr),
        .data_o    (din)
    );

    ssmc_sram_sleep_mode_control dut (
        .CLK_I                         (clk),
        .RST_I                         (rst),
        .SLEEP_REQUEST_I               (slp_req),
        .SLEEP_O                       (slp_st),
        .PROCESSOR_ADDRESS_STROBE_N_I  (pn),
        .CONTROLLER_ADDRESS_STROBE_N_I (cn),
        .CHIP_SELECT_N_I               (sel[2]),
        .EXP_SELECT_I                  (sel[1]),
        .EXP_SELECT_N_I                (sel[0]),
        .ADDR_I                        (addr),
        .WRITE_N_I                     (wn),
        .OUTPUT_ENABLE_N_I             (oen),
        .DQ_I                          (din),
        .DQ_O                          (dout),
        .DQ_OE_N_O                     (dq_oe_n)
    );

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_rw();
        m.op(1'b1, 1'b0, 1'b0, 1'b0, GOOD, 18'h5, 36'h9a5a5a5a5);
        chk(36'(dq_oe_n), 36'h1);
        m.op(1'b0, 1'b1, 1'b1, 1'b0, GOOD, 18'h5, 36'h0);
        chk(dout, 36'h9a5a5a5a5);
        chk(36'(dq_oe_n), 36'h0);
        // Still selected with no strobe: the idle edge is a continuation read
        @(posedge clk);
        #1;
        chk(36'(dq_oe_n), 36'h0);
        m.op(1'b1, 1'b0, 1'b1, 1'b0, 3'h7, 18'h5, 36'h0);
        chk(36'(dq_oe_n), 36'h1);
        m.op(1'b0, 1'b1, 1'b1, 1'b1, GOOD, 18'h5, 36'h0);
        chk(36'(dq_oe_n), 36'h1);
        $display("test rw done");
    endtask

    task automatic t_sel();
        logic [2:0] s;
        for (int i = 0; i < 3; i++) begin
            s = GOOD ^ (3'h1 << i);
            m.op(1'b1, 1'b0, 1'b0, 1'b0, s, 18'h5, 36'h0);
            m.op(1'b0, 1'b1, 1'b1, 1'b0, s, 18'h5, 36'h0);
            chk(36'(dq_oe_n), 36'h1);
            m.op(1'b0, 1'b1, 1'b1, 1'b0, GOOD, 18'h5, 36'h0);
            chk(dout, 36'h9a5a5a5a5);
        end
        $display("test sel done");
    endtask

    task automatic t_sleep();
        m.slp(1'b1);
        // Write lands on the second edge seeing the request
        m.op(1'b1, 1'b0, 1'b0, 1'b0, GOOD, 18'h7, 36'h123456789);
        chk(36'(slp_st), 36'h0);
        @(posedge clk);
        #1;
        chk(36'(slp_st), 36'h1);
        m.op(1'b1, 1'b0, 1'b0, 1'b0, GOOD, 18'h7, 36'h0);
        m.op(1'b0, 1'b1, 1'b1, 1'b0, GOOD, 18'h7, 36'h0);
        chk(36'(dq_oe_n), 36'h1);
        chk(36'(slp_st), 36'h1);
        m.slp(1'b0);
        chk(36'(slp_st), 36'h0);
        m.op(1'b0, 1'b1, 1'b1, 1'b0, GOOD, 18'h7, 36'h0);
        chk(dout, 36'h123456789);
        chk(36'(dq_oe_n), 36'h0);
        $display("test sleep done");
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #5000;
        num_errors = num_errors + 1;
        final_report();
    end

    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_rw();
        t_sel();
        t_sleep();
        final_report();
    end
endmodule
`default_nettype wire
